// *** common/ulc_pkg.sv ***
// Purpose: Shared constants for the serial port line-control and framing block
// Assumes: 200 MHz system clock, byte-wide register window with 3-bit offsets
// Notes: Offsets are the register window's byte offsets from the port base
package ulc_pkg;
    // Register offsets
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IRQ_ENABLE = 3'h1;
    localparam logic [2:0] OFS_IRQ_ID = 3'h2;
    localparam logic [2:0] OFS_LINE_CONTROL = 3'h3;
    // Line-control field positions
    localparam int LC_DIVISOR_LATCH_ACCESS = 7;
    localparam int LC_FORCE_SILENCE = 6;
    localparam int LC_FIXED_PARITY_ENABLE = 5;
    localparam int LC_PARITY_SENSE = 4;
    localparam int LC_PARITY_ENABLE = 3;
    localparam int LC_EXTRA_STOP_BITS = 2;
    localparam int LC_CHAR_LENGTH_HI = 1;
    localparam int LC_CHAR_LENGTH_LO = 0;
    // Reset values
    localparam logic [7:0] LINE_CONTROL_RESET = 8'h00;
    localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;
    localparam logic [15:0] DIVISOR_RESET = 16'h0001;
    // Identification read value when nothing is pending
    localparam logic [7:0] IRQ_ID_IDLE = 8'h01;
    // Timing: each bit time is 16 sample ticks, a half stop is 8
    localparam logic [3:0] TICKS_PER_BIT_M1 = 4'hF;
    localparam logic [3:0] TICKS_HALF_M1 = 4'h7;
    localparam logic [3:0] TICKS_MID = 4'h7;
    // FIFO shape
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    // Framer states, Gray along the usual path
    typedef enum logic [2:0] {
        ULC_IDLE = 3'h0,
        ULC_START = 3'h1,
        ULC_DATA = 3'h3,
        ULC_PARITY = 3'h2,
        ULC_STOP = 3'h6
    } ulc_state_type;
endpackage

// *** core/ulc_fifo.sv ***
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Push and pop may share a cycle
`timescale 1ns/100ps
`default_nettype none
module ulc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    // Storage and pointers
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // Next pointer and count values
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // Register pointers and store data
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (clk_en) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            if (push) begin
                mem[wr_ptr] <= in_data;
            end
        end
    end
endmodule // ulc_fifo
`default_nettype wire

// *** core/ulc_line_control.sv ***
// Purpose: Register window, character framing and line control of one serial port
// Assumes: Serial input is asynchronous to clk_sys
// Notes: Transmit bytes queue in a FIFO; a bit time is 16 ticks
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R01 - Access bit set maps offsets 0,1 to divisor
// R02 - Access bit clear: data buffers, interrupt enable
// R03 - Force silence drives infrared output low
// R04 - Fixed parity: constant inverse of sense bit
// R05 - Parity computed from count of data ones
// R06 - Parity bit follows last data bit
// R07 - One stop bit when extra control clear
// R08 - Five-bit characters use one and half stops
// R09 - Six to eight bits use two stops
// R10 - Length bits select five to eight data
// R11 - Bit zero is least significant, first serial
// R12 - Missing stop bit flags framing error
// R13 - Parity mismatch flags parity error
// R14 - Full character of zeros flags break
// R15 - Idle high, start low, stops high
// R16 - Interrupt enable upper nibble reads zero
module ulc_line_control (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic serial_in,
    output logic serial_out,
    output logic infrared_tx_out,
    output logic tx_ready,
    output logic framing_error,
    output logic parity_error,
    output logic break_detected,
    output logic rx_valid
);
    // Registers seen by software
    logic [7:0] line_control;
    logic [3:0] irq_enable;
    logic [15:0] divisor;
    logic [7:0] rx_buffer;
    logic [7:0] next_line_control;
    logic [3:0] next_irq_enable;
    logic [15:0] next_divisor;
    logic [7:0] next_reg_rdata;
    // Decoded line-control fields
    logic dlab;
    logic [3:0] data_bits;
    // Input synchroniser
    logic rx_meta;
    logic rx_sync;
    // Sample tick generator
    logic [15:0] tick_cnt;
    logic [15:0] next_tick_cnt;
    logic tick;
    // Transmit FIFO wiring
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    // Transmitter state
    ulc_pkg::ulc_state_type tx_state;
    ulc_pkg::ulc_state_type next_tx_state;
    logic [7:0] tx_shift;
    logic [7:0] next_tx_shift;
    logic [3:0] tx_tick;
    logic [3:0] next_tx_tick;
    logic [3:0] tx_bit;
    logic [3:0] next_tx_bit;
    logic tx_line;
    logic next_tx_line;
    logic tx_par;
    logic next_tx_par;
    // Receiver state
    ulc_pkg::ulc_state_type rx_state;
    ulc_pkg::ulc_state_type next_rx_state;
    logic [7:0] rx_shift;
    logic [7:0] next_rx_shift;
    logic [3:0] rx_tick;
    logic [3:0] next_rx_tick;
    logic [3:0] rx_bit;
    logic [3:0] next_rx_bit;
    logic rx_par_bit;
    logic next_rx_par_bit;
    logic rx_any_one;
    logic next_rx_any_one;
    logic [7:0] next_rx_buffer;
    logic next_framing_error;
    logic next_parity_error;
    logic next_break_detected;
    logic next_rx_valid;

    // Number of data bits for a length code
    function automatic logic [3:0] len_of(input logic [7:0] lc);
        len_of = 4'h5 + {2'h0, lc[ulc_pkg::LC_CHAR_LENGTH_HI], lc[ulc_pkg::LC_CHAR_LENGTH_LO]}; // R10
    endfunction

    // Expected parity bit for data under the given settings
    function automatic logic par_of(input logic [7:0] lc, input logic [7:0] d, input logic [3:0] n);
        logic ones;
        ones = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(n)) begin
                ones = ones ^ d[i];
            end
        end
        if (lc[ulc_pkg::LC_FIXED_PARITY_ENABLE]) begin
            par_of = ~lc[ulc_pkg::LC_PARITY_SENSE]; // R04
        end else begin
            par_of = lc[ulc_pkg::LC_PARITY_SENSE] ? ~ones : ones; // R05
        end
    endfunction

    // Stop period in ticks minus one: one, one and a half or two bits
    function automatic logic [4:0] stop_ticks(input logic [7:0] lc);
        if (!lc[ulc_pkg::LC_EXTRA_STOP_BITS]) begin
            stop_ticks = {1'b0, ulc_pkg::TICKS_PER_BIT_M1}; // R07
        end else if (len_of(lc) == 4'h5) begin
            stop_ticks = 5'd23; // R08
        end else begin
            stop_ticks = 5'd31; // R09
        end
    endfunction

    assign dlab = line_control[ulc_pkg::LC_DIVISOR_LATCH_ACCESS];
    assign data_bits = len_of(line_control);
    assign tick = (tick_cnt == 16'h0000);
    assign fifo_in_valid = reg_wr && !dlab && (reg_addr == ulc_pkg::OFS_DATA); // R02
    assign fifo_out_ready = (tx_state == ulc_pkg::ULC_IDLE) && tick;

    // Transmit queue between register write and framer
    ulc_fifo #(
        .WIDTH(ulc_pkg::FIFO_WIDTH),
        .DEPTH(ulc_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .clk_en(clk_en),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(reg_wdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Register writes and read data selection
    always_comb begin
        next_line_control = line_control;
        next_irq_enable = irq_enable;
        next_divisor = divisor;
        next_reg_rdata = reg_rdata;
        next_tick_cnt = tick ? divisor - 16'h0001 : tick_cnt - 16'h0001;
        if (divisor == 16'h0000) begin
            next_tick_cnt = 16'h0000;
        end
        if (reg_wr) begin
            case (reg_addr)
                ulc_pkg::OFS_DATA: begin
                    if (dlab) begin
                        next_divisor[7:0] = reg_wdata; // R01
                    end
                end
                ulc_pkg::OFS_IRQ_ENABLE: begin
                    if (dlab) begin
                        next_divisor[15:8] = reg_wdata; // R01
                    end else begin
                        next_irq_enable = reg_wdata[3:0]; // R02 R16
                    end
                end
                ulc_pkg::OFS_LINE_CONTROL: begin
                    next_line_control = reg_wdata;
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ulc_pkg::OFS_DATA: next_reg_rdata = dlab ? divisor[7:0] : rx_buffer; // R01 R02
                ulc_pkg::OFS_IRQ_ENABLE: next_reg_rdata = dlab ? divisor[15:8] : {4'h0, irq_enable}; // R01 R16
                ulc_pkg::OFS_IRQ_ID: next_reg_rdata = ulc_pkg::IRQ_ID_IDLE;
                ulc_pkg::OFS_LINE_CONTROL: next_reg_rdata = line_control;
                default: next_reg_rdata = 8'h00;
            endcase
        end
    end

    // Register file and tick counter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            line_control <= ulc_pkg::LINE_CONTROL_RESET;
            irq_enable <= ulc_pkg::IRQ_ENABLE_RESET;
            divisor <= ulc_pkg::DIVISOR_RESET;
            reg_rdata <= 8'h00;
            tick_cnt <= 16'h0000;
            tx_ready <= 1'b0;
        end else if (clk_en) begin
            line_control <= next_line_control;
            irq_enable <= next_irq_enable;
            divisor <= next_divisor;
            reg_rdata <= next_reg_rdata;
            tick_cnt <= next_tick_cnt;
            tx_ready <= fifo_in_ready;
        end
    end

    // Transmit framer next state
    always_comb begin
        next_tx_state = tx_state;
        next_tx_shift = tx_shift;
        next_tx_tick = tx_tick;
        next_tx_bit = tx_bit;
        next_tx_line = tx_line;
        next_tx_par = tx_par;
        if (tick) begin
            next_tx_tick = tx_tick + 4'h1;
            case (tx_state)
                ulc_pkg::ULC_IDLE: begin
                    next_tx_line = 1'b1; // R15
                    if (fifo_out_valid) begin
                        next_tx_shift = fifo_out_data;
                        next_tx_par = par_of(line_control, fifo_out_data, data_bits);
                        next_tx_line = 1'b0; // R15
                        next_tx_tick = 4'h0;
                        next_tx_state = ulc_pkg::ULC_START;
                    end
                end
                ulc_pkg::ULC_START: begin
                    if (tx_tick == ulc_pkg::TICKS_PER_BIT_M1) begin
                        next_tx_line = tx_shift[0]; // R11
                        next_tx_bit = 4'h0;
                        next_tx_state = ulc_pkg::ULC_DATA;
                    end
                end
                ulc_pkg::ULC_DATA: begin
                    if (tx_tick == ulc_pkg::TICKS_PER_BIT_M1) begin
                        next_tx_shift = {1'b0, tx_shift[7:1]}; // R11
                        next_tx_bit = tx_bit + 4'h1;
                        if (tx_bit + 4'h1 == data_bits) begin
                            if (line_control[ulc_pkg::LC_PARITY_ENABLE]) begin
                                next_tx_line = tx_par; // R06
                                next_tx_state = ulc_pkg::ULC_PARITY;
                            end else begin
                                next_tx_line = 1'b1;
                                next_tx_bit = 4'h0;
                                next_tx_state = ulc_pkg::ULC_STOP;
                            end
                        end else begin
                            next_tx_line = tx_shift[1];
                        end
                    end
                end
                ulc_pkg::ULC_PARITY: begin
                    if (tx_tick == ulc_pkg::TICKS_PER_BIT_M1) begin
                        next_tx_line = 1'b1; // R15
                        next_tx_bit = 4'h0;
                        next_tx_state = ulc_pkg::ULC_STOP;
                    end
                end
                ulc_pkg::ULC_STOP: begin
                    // Whole stop bits in tx_bit, ticks in tx_tick
                    if ({tx_bit[0], tx_tick} == stop_ticks(line_control)) begin // R07 R08 R09
                        next_tx_state = ulc_pkg::ULC_IDLE;
                    end
                    if (tx_tick == ulc_pkg::TICKS_PER_BIT_M1) begin
                        next_tx_bit = tx_bit + 4'h1;
                    end
                end
                default: begin
                    next_tx_state = ulc_pkg::ULC_IDLE;
                    next_tx_line = 1'b1;
                end
            endcase
        end
    end

    // Transmit framer registers and line outputs
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_state <= ulc_pkg::ULC_IDLE;
            tx_shift <= 8'h00;
            tx_tick <= 4'h0;
            tx_bit <= 4'h0;
            tx_line <= 1'b1;
            tx_par <= 1'b0;
            serial_out <= 1'b1;
            infrared_tx_out <= 1'b1;
        end else if (clk_en) begin
            tx_state <= next_tx_state;
            tx_shift <= next_tx_shift;
            tx_tick <= next_tx_tick;
            tx_bit <= next_tx_bit;
            tx_line <= next_tx_line;
            tx_par <= next_tx_par;
            serial_out <= next_tx_line;
            infrared_tx_out <= next_tx_line && !line_control[ulc_pkg::LC_FORCE_SILENCE]; // R03
        end
    end

    // Two-stage synchroniser for the serial input
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else if (clk_en) begin
            rx_meta <= serial_in;
            rx_sync <= rx_meta;
        end
    end

    // Receive framer next state, sampling at bit centres
    always_comb begin
        next_rx_state = rx_state;
        next_rx_shift = rx_shift;
        next_rx_tick = rx_tick;
        next_rx_bit = rx_bit;
        next_rx_par_bit = rx_par_bit;
        next_rx_any_one = rx_any_one;
        next_rx_buffer = rx_buffer;
        next_framing_error = framing_error;
        next_parity_error = parity_error;
        next_break_detected = break_detected;
        next_rx_valid = 1'b0;
        // A line-control read clears the sticky flags; a set below wins
        if (reg_rd && reg_addr == ulc_pkg::OFS_LINE_CONTROL) begin
            next_framing_error = 1'b0;
            next_parity_error = 1'b0;
            next_break_detected = 1'b0;
        end
        if (tick) begin
            next_rx_tick = rx_tick + 4'h1;
            case (rx_state)
                ulc_pkg::ULC_IDLE: begin
                    if (!rx_sync) begin // R15
                        next_rx_tick = 4'h0;
                        next_rx_any_one = 1'b0;
                        next_rx_state = ulc_pkg::ULC_START;
                    end
                end
                ulc_pkg::ULC_START: begin
                    if (rx_tick == ulc_pkg::TICKS_MID) begin
                        next_rx_tick = 4'h0;
                        next_rx_bit = 4'h0;
                        next_rx_state = rx_sync ? ulc_pkg::ULC_IDLE : ulc_pkg::ULC_DATA;
                    end
                end
                ulc_pkg::ULC_DATA: begin
                    if (rx_tick == ulc_pkg::TICKS_PER_BIT_M1) begin
                        next_rx_shift = {rx_sync, rx_shift[7:1]}; // R11
                        next_rx_any_one = rx_any_one | rx_sync;
                        next_rx_bit = rx_bit + 4'h1;
                        if (rx_bit + 4'h1 == data_bits) begin
                            next_rx_bit = 4'h0;
                            next_rx_state = line_control[ulc_pkg::LC_PARITY_ENABLE] ?
                                ulc_pkg::ULC_PARITY : ulc_pkg::ULC_STOP; // R06
                        end
                    end
                end
                ulc_pkg::ULC_PARITY: begin
                    if (rx_tick == ulc_pkg::TICKS_PER_BIT_M1) begin
                        next_rx_par_bit = rx_sync;
                        next_rx_any_one = rx_any_one | rx_sync;
                        next_rx_state = ulc_pkg::ULC_STOP;
                    end
                end
                ulc_pkg::ULC_STOP: begin
                    // Stop samples at each whole stop bit centre and when the stop_ticks count is reached
                    if (rx_tick == ulc_pkg::TICKS_PER_BIT_M1 ||
                        ({rx_bit[0], rx_tick} == stop_ticks(line_control))) begin
                        next_rx_any_one = rx_any_one | rx_sync;
                        next_rx_bit = rx_bit + 4'h1;
                        if (!rx_sync) begin
                            next_framing_error = 1'b1; // R12 R07 R08 R09
                        end
                    end
                    if ({rx_bit[0], rx_tick} == stop_ticks(line_control)) begin
                        next_rx_buffer = rx_shift >> (4'h8 - data_bits); // R10 R11
                        next_rx_valid = 1'b1;
                        if (line_control[ulc_pkg::LC_PARITY_ENABLE] &&
                            rx_par_bit != par_of(line_control, rx_shift >> (4'h8 - data_bits), data_bits)) begin
                            next_parity_error = 1'b1; // R13 R04 R05
                        end
                        if (!(rx_any_one | rx_sync)) begin
                            next_break_detected = 1'b1; // R14
                        end
                        next_rx_state = ulc_pkg::ULC_IDLE;
                    end
                end
                default: begin
                    next_rx_state = ulc_pkg::ULC_IDLE;
                end
            endcase
        end
    end

    // Receive framer registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rx_state <= ulc_pkg::ULC_IDLE;
            rx_shift <= 8'h00;
            rx_tick <= 4'h0;
            rx_bit <= 4'h0;
            rx_par_bit <= 1'b0;
            rx_any_one <= 1'b0;
            rx_buffer <= 8'h00;
            framing_error <= 1'b0;
            parity_error <= 1'b0;
            break_detected <= 1'b0;
            rx_valid <= 1'b0;
        end else if (clk_en) begin
            rx_state <= next_rx_state;
            rx_shift <= next_rx_shift;
            rx_tick <= next_rx_tick;
            rx_bit <= next_rx_bit;
            rx_par_bit <= next_rx_par_bit;
            rx_any_one <= next_rx_any_one;
            rx_buffer <= next_rx_buffer;
            framing_error <= next_framing_error;
            parity_error <= next_parity_error;
            break_detected <= next_break_detected;
            rx_valid <= next_rx_valid;
        end
    end
endmodule // ulc_line_control
`default_nettype wire

// *** verification/ulc_line_control_assertions.sv ***
// Purpose: Port-level checks for the line-control block
// Assumes: Writes land at the strobe's edge
// Notes: A shadow of line_control judges silence and readback
`timescale 1ns/100ps
`default_nettype none
module ulc_line_control_assertions (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [2:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic serial_out,
    input wire logic infrared_tx_out,
    input wire logic framing_error,
    input wire logic parity_error,
    input wire logic rx_valid
);
    logic [7:0] lc;  // Shadow of line_control
    logic lc_rd;  // Taken read of offset 3
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    assign lc_rd = clk_en && reg_rd && reg_addr == 3'h3;
    // Follow host writes to line_control
    always_ff @(posedge clk_sys) begin
        lc <= srst ? 8'h00 : (clk_en && reg_wr && reg_addr == 3'h3) ? reg_wdata : lc;
    end
    // Start bit holds low at least half a bit
    sequence low8_s;
        !serial_out [*8];
    endsequence
    silence_low_a: assert property (lc[6] && $past(lc[6]) |-> !infrared_tx_out)
        else $error("infrared not silent");
    ir_follow_a: assert property (!lc[6] && !$past(lc[6]) |-> infrared_tx_out == serial_out)
        else $error("infrared differs");
    lc_readback_a: assert property (lc_rd |=> reg_rdata == $past(lc))
        else $error("line_control readback");
    ien_upper_a: assert property (clk_en && reg_rd && reg_addr == 3'h1 && !lc[7] |=> reg_rdata[7:4] == 4'h0)
        else $error("irq_enable upper bits");
    rdata_hold_a: assert property (!(clk_en && reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved");
    rx_pulse_a: assert property (rx_valid |=> !rx_valid)
        else $error("rx_valid too long");
    frame_sticky_a: assert property (framing_error && !lc_rd |=> framing_error)
        else $error("framing flag lost");
    parity_sticky_a: assert property (parity_error && !lc_rd |=> parity_error)
        else $error("parity flag lost");
    start_width_a: assert property ($fell(serial_out) |-> low8_s)
        else $error("start bit short");
endmodule  // ulc_line_control_assertions
bind ulc_line_control ulc_line_control_assertions u_chk (.clk_sys, .srst, .clk_en, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .serial_out, .infrared_tx_out, .framing_error, .parity_error, .rx_valid);
`default_nettype wire

// *** verification/ulc_remote_model.sv ***
// Purpose: Remote serial device facing the port
// Assumes: Divisor 1, one bit is 16 clocks; called on falling edges
// Notes: Line idles high between characters
`timescale 1ns/100ps
`default_nettype none
module ulc_remote_model (
    input wire logic clk_sys,
    input wire logic serial_out,
    output logic serial_in
);
    initial serial_in = 1'b1;
    // Shift a frame out, first bit first
    task automatic send(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            serial_in = v[i];
            repeat (16) @(negedge clk_sys);
        end
        serial_in = 1'b1;
    endtask
    // Sample a frame at mid-bit; unknown on timeout
    task automatic grab(input int n, output logic [15:0] v);
        int t = 0;
        v = 'x;
        while (serial_out === 1'b1 && t < 4000) begin
            @(negedge clk_sys);
            t++;
        end
        if (t == 4000) return;
        v = 16'hFFFF;
        repeat (8) @(negedge clk_sys);
        for (int i = 0; i < n; i++) begin
            v[i] = serial_out;
            repeat (16) @(negedge clk_sys);
        end
    endtask
endmodule  // ulc_remote_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: Self-checking bench for the line-control block
// Assumes: Divisor stays 1, so one bit is 16 clocks
// Notes: Frames are predicted from line_control
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0, srst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, lc, d;
    logic serial_in, serial_out, infrared_tx_out, tx_ready, framing_error, parity_error, break_detected, rx_valid;
    logic [15:0] e, got;
    logic [31:0] seed = 32'h13998792;
    int bad_count = 0, checks_done = 0, n, k;
    always #2.5 clk_sys = ~clk_sys;
    ulc_line_control dut (.clk_sys, .srst, .clk_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .serial_in, .serial_out, .infrared_tx_out, .tx_ready, .framing_error, .parity_error, .break_detected,
        .rx_valid);
    ulc_remote_model rem (.clk_sys, .serial_out, .serial_in);
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Predicted frame, padded with idle ones
    function automatic logic [15:0] frame(logic [7:0] c, logic [7:0] v, output int m);
        int len = 5 + int'(c[1:0]);
        logic p = 1'b0;
        frame = 16'hFFFF;
        frame[0] = 1'b0;
        for (int i = 0; i < len; i++) begin
            frame[1 + i] = v[i];
            p ^= v[i];
        end
        p = c[5] ? !c[4] : p ^ c[4];
        if (c[3]) frame[1 + len] = p;
        m = 2 + len + int'(c[3]);
    endfunction
    task automatic chk(string s, logic [15:0] g, logic [15:0] x);
        checks_done++;
        if (g !== x) begin
            bad_count++;
            $display("FAIL %s exp %h got %h", s, x, g);
        end
    endtask
    task automatic results();
        if (bad_count == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One register access, strobe held for one edge
    task automatic acc(logic w, logic [2:0] a, logic [7:0] v);
        reg_wr = w;
        reg_rd = !w;
        reg_addr = a;
        reg_wdata = v;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(string s, logic [2:0] a, logic [7:0] x);
        acc(1'b0, a, seed[7:0]);
        chk(s, {8'h00, reg_rdata}, {8'h00, x});
    endtask
    // Bounded wait for rx_valid (0) or tx_ready (1)
    task automatic hold(int lim, int sel);
        int t = 0;
        while ((sel ? tx_ready : rx_valid) !== 1'b1 && t < lim) begin
            @(negedge clk_sys);
            t++;
        end
        if (t == lim) begin
            bad_count++;
            results();
        end
    endtask
    initial begin
        repeat (3) @(negedge clk_sys);
        srst = 1'b0;
        rd("lc", 3'h3, 8'h00);
        acc(1'b1, 3'h1, 8'hFF);
        rd("ien", 3'h1, 8'h0F);
        acc(1'b1, 3'h3, 8'h83);
        acc(1'b1, 3'h0, 8'h01);
        acc(1'b1, 3'h1, 8'h00);
        rd("dll", 3'h0, 8'h01);
        rd("dlh", 3'h1, 8'h00);
        acc(1'b1, 3'h3, 8'h03);
        rd("ien2", 3'h1, 8'h0F);
        rd("id", 3'h2, 8'h01);
        rd("gap", 3'h5, 8'h00);
        // Every length and stop mode, parity on and off; fixed parity only with sense clear
        for (k = 0; k < 16; k++) begin
            lc = 8'((k * 13) % 64) | (k == 5 ? 8'h40 : 8'h00);
            seed = lfsr(seed);
            d = seed[7:0] & (8'hFF >> (3 - lc[1:0]));
            acc(1'b1, 3'h3, lc);
            e = frame(lc, d, n);
            acc(1'b1, 3'h0, d);
            rem.grab(n, got);
            chk("tx", got, e);
            repeat (48) @(negedge clk_sys);
            fork
                rem.send(e, n + 1);
                hold(3000, 0);
            join
            rd("rx", 3'h0, d);
            chk("err", 16'({framing_error, parity_error, break_detected}), 16'h0);
            rd("lcx", 3'h3, lc);
        end
        acc(1'b1, 3'h3, 8'h0B);
        e = frame(8'h0B, 8'h5A, n);
        rem.send(e ^ 16'h0200, n + 1);
        repeat (20) @(negedge clk_sys);
        chk("par", 16'(parity_error), 16'h1);
        rd("lc2", 3'h3, 8'h0B);
        rem.send(e & 16'hFBFF, n);
        repeat (20) @(negedge clk_sys);
        chk("frm", 16'(framing_error), 16'h1);
        rd("lc3", 3'h3, 8'h0B);
        rem.send(16'h0000, 16);
        repeat (20) @(negedge clk_sys);
        chk("brk", 16'(break_detected), 16'h1);
        // Fill the transmit queue until it refuses
        k = 0;
        while (tx_ready === 1'b1 && k < 20) begin
            acc(1'b1, 3'h0, 8'(k));
            k++;
        end
        chk("fifo", 16'(k >= 16 && k <= 17), 16'h1);
        hold(400, 1);
        results();
    end
endmodule  // tb_top
`default_nettype wire
